// file: logic/ppa_addr_select.sv
// Purpose: Role, address and unit count from the pack switch, link rates, power on/off
// Assumes: Switch, button, external switch and charger are asynchronous pins
// Notes: Decoded role is frozen at each wake and held through power down until the next wake
//
// Added by the designer: the address map and the APB interface to the registers.

`timescale 1ns/100ps
`default_nettype none

// Contract
// - CAN link toward the inverter runs at 500 kbit/s
// - RS485 link between packs runs at 19200 bit/s
// - Positions one to three form address or count; four selects role
// - Position four on gives host role with address fixed at zero
// - Position four off gives slave role, address one to seven
// - Three positions decode binary, weights one, two and four
// - Host unit count is field plus one; all off means stand-alone
// - RS485 is the pack link, CAN the upper link, host gathers slaves
// - Host offers combined pack data to the terminal over CAN
// - Wake on button press, external switch closing or charger applied
// - Off after 6 s button hold or switch opening, chase once first; button hold is ignored while the external switch is closed
module ppa_addr_select #(
   parameter int unsigned HOLD_CYC = ppa_pkg::HOLD_OFF_CYC,
   parameter int unsigned STEP_CYC = ppa_pkg::CHASE_STEP_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ppa_pkg::PADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic role_select_switch,
   input wire logic [ppa_pkg::ADDR_W-1:0] address_count_switches,
   input wire logic reset_button,
   input wire logic ext_switch_closed,
   input wire logic charger_present,
   input wire logic pack_report_valid,
   input wire logic [ppa_pkg::ADDR_W-1:0] pack_report_addr,
   input wire logic [ppa_pkg::PACK_W-1:0] pack_report_value,
   output ppa_pkg::ppa_cfg_s cfg,
   output logic power_on,
   output logic [ppa_pkg::LED_N-1:0] indicator,
   output logic can_enable,
   output logic can_bit_tick,
   output logic rs485_enable,
   output logic rs485_poll_master,
   output logic rs485_bit_tick,
   output logic [ppa_pkg::TOTAL_W-1:0] can_total
);
   import ppa_pkg::*;

   localparam logic [TIMER_W-1:0] HOLD_LAST = TIMER_W'(HOLD_CYC - 1);
   localparam logic [TIMER_W-1:0] STEP_LAST = TIMER_W'(STEP_CYC - 1);
   localparam logic [BAUD_W-1:0] CAN_LAST = BAUD_W'(CAN_BIT_CYC - 1);
   localparam logic [BAUD_W-1:0] RS485_LAST = BAUD_W'(RS485_BIT_CYC - 1);
   localparam logic [LED_IDX_W-1:0] LED_LAST = LED_IDX_W'(LED_N - 1);

   // ==========================================================
   // Pin synchronisers
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   logic [SYNC_W-1:0] sync3;
   logic [SYNC_W-1:0] pin_clean;
   logic [SYNC_W-1:0] pin_prev;
   logic [SYNC_W-1:0] agree;
   logic [SYNC_W-1:0] next_clean;

   assign pin_raw = {charger_present, ext_switch_closed, reset_button,
                     role_select_switch, address_count_switches};
   assign agree = ~(sync2 ^ sync3);
   // A bit only moves once the second and third stages match
   assign next_clean = (agree & sync3) | (~agree & pin_clean);

   // Three stage chain, first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         pin_clean <= '0;
         pin_prev <= '0;
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         sync3 <= sync2;
         pin_clean <= next_clean;
         pin_prev <= pin_clean;
      end
   end

   // ==========================================================
   // Power events
   logic button_held;
   logic button_press;
   logic ext_closed;
   logic ext_close_edge;
   logic ext_open_edge;
   logic charger_edge;
   logic wake_event;

   assign button_held = pin_clean[SY_BUTTON];
   assign button_press = pin_clean[SY_BUTTON] & ~pin_prev[SY_BUTTON];
   assign ext_closed = pin_clean[SY_EXT];
   assign ext_close_edge = pin_clean[SY_EXT] & ~pin_prev[SY_EXT];
   assign ext_open_edge = ~pin_clean[SY_EXT] & pin_prev[SY_EXT];
   assign charger_edge = pin_clean[SY_CHARGER] & ~pin_prev[SY_CHARGER];
   assign wake_event = button_press | ext_close_edge | charger_edge;

   // ==========================================================
   // Switch decode
   logic sw_role;
   logic [ADDR_W-1:0] sw_field;
   ppa_cfg_s next_cfg;

   assign sw_role = pin_clean[SY_ROLE];
   assign sw_field = pin_clean[ADDR_W-1:0];
   assign next_cfg.is_host = sw_role;
   assign next_cfg.node_addr = sw_role ? HOST_ADDR : sw_field;
   assign next_cfg.unit_count = sw_role ? (UNIT_W'(sw_field) + ONE_UNIT) : ONE_UNIT;
   assign next_cfg.standalone = ~sw_role & (sw_field == NO_SLAVES);

   // ==========================================================
   // Power state machine
   ppa_power_e state;
   ppa_power_e next_state;
   logic [TIMER_W-1:0] hold_cnt;
   logic [TIMER_W-1:0] step_cnt;
   logic [LED_IDX_W-1:0] led_idx;
   logic chasing;
   logic chase_done;
   logic hold_done;
   logic entering_wake;

   assign chasing = (state == PW_WAKE) || (state == PW_SHUT);
   assign chase_done = chasing && (led_idx == LED_LAST) && (step_cnt == STEP_LAST);
   assign hold_done = button_held && (hold_cnt == HOLD_LAST);
   assign entering_wake = (state == PW_OFF) && wake_event;

   // Next state; external switch has priority over the button
   always_comb begin
      next_state = state;
      case (state)
         PW_OFF: begin
            if (wake_event) begin
               next_state = PW_WAKE;
            end
         end
         PW_WAKE: begin
            if (chase_done) begin
               next_state = PW_ON;
            end
         end
         PW_ON: begin
            if (ext_open_edge || (hold_done && !ext_closed)) begin
               next_state = PW_SHUT;
            end
         end
         PW_SHUT: begin
            if (chase_done) begin
               next_state = PW_OFF;
            end
         end
         default: begin
            next_state = PW_OFF;
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= PW_OFF;
      end else begin
         state <= next_state;
      end
   end

   // Button hold timer, restarts on every release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt <= '0;
      end else if (!button_held || state != PW_ON) begin
         hold_cnt <= '0;
      end else if (hold_cnt != HOLD_LAST) begin
         hold_cnt <= hold_cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_cnt <= '0;
         led_idx <= '0;
      end else if (!chasing || chase_done) begin
         step_cnt <= '0;
         led_idx <= '0;
      end else if (step_cnt == STEP_LAST) begin
         step_cnt <= '0;
         led_idx <= led_idx + 1'b1;
      end else begin
         step_cnt <= step_cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= '0;
      end else if (entering_wake) begin
         cfg <= next_cfg;
      end
   end

   // Lamp pattern registered so the pins never glitch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         indicator <= '0;
      end else if (chasing && !chase_done) begin
         indicator <= LED_N'(1) << led_idx;
      end else begin
         indicator <= '0;
      end
   end

   assign power_on = (state != PW_OFF);

   // ==========================================================
   // Software control
   logic [1:0] ctrl;

   assign can_enable = power_on && cfg.is_host && ctrl[CTRL_CAN_EN];
   assign rs485_enable = power_on && ctrl[CTRL_485_EN];
   assign rs485_poll_master = rs485_enable && cfg.is_host;

   // ==========================================================
   // Bit rate generators
   logic [BAUD_W-1:0] can_cnt;
   logic [BAUD_W-1:0] rs485_cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         can_cnt <= '0;
         can_bit_tick <= 1'b0;
      end else if (!can_enable) begin
         can_cnt <= '0;
         can_bit_tick <= 1'b0;
      end else begin
         can_bit_tick <= (can_cnt == CAN_LAST);
         can_cnt <= (can_cnt == CAN_LAST) ? '0 : can_cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rs485_cnt <= '0;
         rs485_bit_tick <= 1'b0;
      end else if (!rs485_enable) begin
         rs485_cnt <= '0;
         rs485_bit_tick <= 1'b0;
      end else begin
         rs485_bit_tick <= (rs485_cnt == RS485_LAST);
         rs485_cnt <= (rs485_cnt == RS485_LAST) ? '0 : rs485_cnt + 1'b1;
      end
   end

   // ==========================================================
   // Pack data gathering
   logic [PACK_W-1:0] pack_data [PACK_N];
   logic [PACK_N-1:0] pack_seen;
   logic [TOTAL_W-1:0] next_total;
   logic [CNT_W-1:0] seen_count;
   logic take_report;

   assign take_report = pack_report_valid && cfg.is_host && (state == PW_ON);

   always_comb begin
      next_total = '0;
      seen_count = '0;
      for (int i = 0; i < PACK_N; i++) begin
         if (pack_seen[i]) begin
            next_total = next_total + TOTAL_W'(pack_data[i]);
            seen_count = seen_count + 1'b1;
         end
      end
   end

   // Slots cleared on wake so stale packs never count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pack_seen <= '0;
         for (int i = 0; i < PACK_N; i++) begin
            pack_data[i] <= '0;
         end
      end else if (entering_wake) begin
         pack_seen <= '0;
      end else if (take_report) begin
         pack_seen[pack_report_addr] <= 1'b1;
         pack_data[pack_report_addr] <= pack_report_value;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         can_total <= '0;
      end else begin
         can_total <= next_total;
      end
   end

   // ==========================================================
   // APB slave, zero wait states
   logic hit_ctrl;
   logic hit_status;
   logic hit_total;
   logic hit_count;
   logic hit_any;
   logic setup_phase;
   logic write_take;
   logic [31:0] status_word;
   logic [31:0] read_mux;

   assign hit_ctrl = (paddr == REG_CTRL);
   assign hit_status = (paddr == REG_STATUS);
   assign hit_total = (paddr == REG_TOTAL);
   assign hit_count = (paddr == REG_COUNT);
   assign hit_any = hit_ctrl | hit_status | hit_total | hit_count;
   assign setup_phase = psel && !penable;
   assign write_take = psel && penable && pwrite && hit_ctrl;
   assign pready = 1'b1;
   // Unmapped addresses flag an error in the access phase
   assign pslverr = psel && penable && !hit_any;

   assign status_word = (32'(power_on) << ST_POWER)
                      | (32'(cfg.is_host) << ST_HOST)
                      | (32'(cfg.node_addr) << ST_ADDR)
                      | (32'(cfg.unit_count) << ST_UNITS)
                      | (32'(cfg.standalone) << ST_ALONE)
                      | (32'(pin_clean[SY_ROLE:0]) << ST_SWITCH);
   assign read_mux = hit_ctrl ? 32'(ctrl)
                   : hit_status ? status_word
                   : hit_total ? 32'(can_total)
                   : hit_count ? 32'(seen_count)
                   : '0;

   // Control register, both links enabled out of reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
      end else if (write_take) begin
         ctrl <= pwdata[1:0];
      end
   end

   // Read data captured in setup, stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup_phase && !pwrite) begin
         prdata <= read_mux;
      end
   end

endmodule

`default_nettype wire

// file: logic/ppa_pkg.sv
// Purpose: Shared constants and types for the parallel pack address select block
// Assumes: 40 MHz pclk, APB register access
// Notes: Times are kept in their own unit and converted to cycles here

package ppa_pkg;

   // ==========================================================
   // Clock and link rates
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned CAN_BPS = 500_000;
   localparam int unsigned RS485_BPS = 19_200;
   localparam int unsigned CAN_BIT_CYC = CLK_HZ / CAN_BPS;
   localparam int unsigned RS485_BIT_CYC = CLK_HZ / RS485_BPS;
   localparam int unsigned BAUD_W = 12;

   // ==========================================================
   // Power button and indicator timing
   localparam int unsigned HOLD_OFF_S = 6;
   localparam int unsigned HOLD_OFF_CYC = HOLD_OFF_S * CLK_HZ;
   localparam int unsigned CHASE_STEP_MS = 250;
   localparam int unsigned CHASE_STEP_CYC = CHASE_STEP_MS * (CLK_HZ / 1000);
   localparam int unsigned TIMER_W = 32;
   localparam int unsigned LED_N = 4;
   localparam int unsigned LED_IDX_W = 2;

   // ==========================================================
   // Switch field layout
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned UNIT_W = 4;
   localparam logic [ADDR_W-1:0] HOST_ADDR = 3'h0;
   localparam logic [ADDR_W-1:0] NO_SLAVES = 3'h0;
   localparam logic [UNIT_W-1:0] ONE_UNIT = 4'h1;
   localparam int unsigned PACK_N = 8;
   localparam int unsigned PACK_W = 16;
   localparam int unsigned TOTAL_W = 19;

   // ==========================================================
   // Synchroniser bit positions
   localparam int unsigned SYNC_W = 7;
   localparam int unsigned SY_ROLE = 3;
   localparam int unsigned SY_BUTTON = 4;
   localparam int unsigned SY_EXT = 5;
   localparam int unsigned SY_CHARGER = 6;

   // ==========================================================
   // Register map, byte addresses
   localparam int unsigned PADDR_W = 8;
   localparam logic [PADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [PADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [PADDR_W-1:0] REG_TOTAL = 8'h08;
   localparam logic [PADDR_W-1:0] REG_COUNT = 8'h0c;
   localparam int unsigned CTRL_CAN_EN = 0;
   localparam int unsigned CTRL_485_EN = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam int unsigned ST_POWER = 0;
   localparam int unsigned ST_HOST = 1;
   localparam int unsigned ST_ADDR = 2;
   localparam int unsigned ST_UNITS = 5;
   localparam int unsigned ST_ALONE = 9;
   localparam int unsigned ST_SWITCH = 10;
   localparam int unsigned CNT_W = 4;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {PW_OFF, PW_WAKE, PW_ON, PW_SHUT} ppa_power_e;

   typedef struct packed {
      logic is_host;
      logic standalone;
      logic [ADDR_W-1:0] node_addr;
      logic [UNIT_W-1:0] unit_count;
   } ppa_cfg_s;

endpackage

// file: tb/ppa_addr_select_assertions.sv
// Purpose: Port checker for the pack address select block
// Assumes: One pclk domain, presetn low clears everything
// Notes: Bit gaps are timed by small counters, not long repeats
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Checker
module ppa_sva
   import ppa_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic reset_button,
   input wire logic ext_switch_closed,
   input wire logic charger_present,
   input wire ppa_pkg::ppa_cfg_s cfg,
   input wire logic power_on,
   input wire logic [3:0] indicator,
   input wire logic can_enable,
   input wire logic can_bit_tick,
   input wire logic rs485_enable,
   input wire logic rs485_poll_master,
   input wire logic rs485_bit_tick
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [11:0] rgap;
   logic [6:0] cgap;
   logic rseen, cseen;
   // Gap since last tick; a gap is only judged between two enabled ticks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rgap <= 12'h0;
         cgap <= 7'h0;
         rseen <= 1'b0;
         cseen <= 1'b0;
      end else begin
         rgap <= rs485_bit_tick ? 12'h0 : rgap + 12'h1;
         cgap <= can_bit_tick ? 7'h0 : cgap + 7'h1;
         rseen <= rs485_bit_tick ? rs485_enable : rseen & rs485_enable;
         cseen <= can_bit_tick ? can_enable : cseen & can_enable;
      end
   end
   property p_can_rate;
      (can_bit_tick && cseen) |-> cgap == 7'h4f;
   endproperty
   a_can_rate: assert property (p_can_rate) else $error("can bit gap wrong");
   property p_485_rate;
      (rs485_bit_tick && rseen) |-> rgap == 12'h822;
   endproperty
   a_485_rate: assert property (p_485_rate) else $error("rs485 bit gap wrong");
   property p_host_addr;
      cfg.is_host |-> cfg.node_addr == 3'h0 && !cfg.standalone && cfg.unit_count != 4'h0;
   endproperty
   a_host_addr: assert property (p_host_addr) else $error("host address not zero");
   property p_slave_addr;
      (power_on && !cfg.is_host && !cfg.standalone) |-> cfg.node_addr != 3'h0;
   endproperty
   a_slave_addr: assert property (p_slave_addr) else $error("slave address zero");
   property p_alone;
      cfg.standalone |-> cfg.unit_count == 4'h1 && cfg.node_addr == 3'h0 && !cfg.is_host;
   endproperty
   a_alone: assert property (p_alone) else $error("stand-alone decode wrong");
   property p_frozen;
      (power_on && $past(power_on)) |-> $stable(cfg);
   endproperty
   a_frozen: assert property (p_frozen) else $error("cfg moved while powered");
   property p_poll;
      rs485_poll_master |-> rs485_enable && cfg.is_host && power_on;
   endproperty
   a_poll: assert property (p_poll) else $error("slave polls pack link");
   property p_can_host;
      can_enable |-> power_on && cfg.is_host;
   endproperty
   a_can_host: assert property (p_can_host) else $error("can up while not host");
   property p_wake;
      (!power_on && ($rose(ext_switch_closed) || $rose(charger_present) || $rose(reset_button)))
         |-> ##[2:10] power_on;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_ext_off;
      (power_on && indicator == 4'h0 && $fell(ext_switch_closed))
         |-> ##[3:12] indicator != 4'h0 ##[8:30] !power_on;
   endproperty
   a_ext_off: assert property (p_ext_off) else $error("no shutdown chase");
endmodule

bind ppa_addr_select ppa_sva u_sva (.pclk(pclk), .presetn(presetn),
   .reset_button(reset_button), .ext_switch_closed(ext_switch_closed),
   .charger_present(charger_present), .cfg(cfg), .power_on(power_on),
   .indicator(indicator), .can_enable(can_enable), .can_bit_tick(can_bit_tick),
   .rs485_enable(rs485_enable), .rs485_poll_master(rs485_poll_master),
   .rs485_bit_tick(rs485_bit_tick));
`default_nettype wire

// file: tb/ppa_peer_packs.sv
// Purpose: Peer packs answering the host poll on the pack link
// Assumes: One answer per link bit tick, slots 0 up to pack_n-1
// Notes: Value of slot i is 0x100 plus i
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Peer pack model
module ppa_peer_packs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rs485_poll_master,
   input wire logic rs485_bit_tick,
   input wire logic [3:0] pack_n,
   output logic pack_report_valid,
   output logic [2:0] pack_report_addr,
   output logic [15:0] pack_report_value
);
   logic [3:0] idx;
   wire logic answer = rs485_poll_master && rs485_bit_tick && idx < pack_n;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx <= 4'h0;
         pack_report_valid <= 1'b0;
         pack_report_addr <= 3'h0;
         pack_report_value <= 16'h0;
      end else begin
         pack_report_valid <= answer;
         if (answer) begin
            idx <= idx + 4'h1;
            pack_report_addr <= idx[2:0];
            pack_report_value <= 16'h0100 + {12'h0, idx};
         end else begin
            // Idle lines toggle so stale data is never mistaken
            pack_report_addr <= ~pack_report_addr;
            pack_report_value <= ~pack_report_value;
            if (!rs485_poll_master) idx <= 4'h0;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Purpose: Self-checking bench for the pack address select block
// Assumes: Short hold and chase counts, APB with zero wait
// Notes: Waits are bounded; a watchdog ends a hang
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Bench top
module tb;
   import ppa_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic role_select_switch, reset_button, ext_switch_closed, charger_present;
   logic [2:0] address_count_switches, pack_report_addr;
   logic pack_report_valid, power_on, can_enable, can_bit_tick;
   logic rs485_enable, rs485_poll_master, rs485_bit_tick;
   logic [15:0] pack_report_value;
   logic [3:0] indicator, pack_n;
   logic [18:0] can_total;
   ppa_cfg_s cfg;
   int checks = 0;
   int mismatches = 0;
   ppa_addr_select #(.HOLD_CYC(20), .STEP_CYC(4)) dut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .role_select_switch(role_select_switch), .address_count_switches(address_count_switches),
      .reset_button(reset_button), .ext_switch_closed(ext_switch_closed),
      .charger_present(charger_present), .pack_report_valid(pack_report_valid),
      .pack_report_addr(pack_report_addr), .pack_report_value(pack_report_value),
      .cfg(cfg), .power_on(power_on), .indicator(indicator), .can_enable(can_enable),
      .can_bit_tick(can_bit_tick), .rs485_enable(rs485_enable),
      .rs485_poll_master(rs485_poll_master), .rs485_bit_tick(rs485_bit_tick),
      .can_total(can_total));
   ppa_peer_packs u_peer (.pclk(pclk), .presetn(presetn), .rs485_poll_master(rs485_poll_master),
      .rs485_bit_tick(rs485_bit_tick), .pack_n(pack_n), .pack_report_valid(pack_report_valid),
      .pack_report_addr(pack_report_addr), .pack_report_value(pack_report_value));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // APB cycle; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      // A slave that never answers counts as a mismatch
      if (pready !== 1'b1) mismatches++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Wait for a settled power state, sampled off the rising edge
   // Two quiet samples in a row: the first wake cycle has power but no lamp yet
   task automatic wait_pow(input logic s);
      int n;
      int quiet;
      n = 0;
      quiet = 0;
      while (quiet < 2 && n < 300) begin
         n++;
         @(negedge pclk);
         quiet = (power_on === s && indicator === 4'h0) ? quiet + 1 : 0;
      end
      chk(32'(power_on), 32'(s));
      @(posedge pclk);
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      close_out();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {role_select_switch, address_count_switches, reset_button} = '0;
      {ext_switch_closed, charger_present, pack_n} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h3);
      apb(1'b0, 8'h10, 32'h0);
      chk(32'(er), 32'h1);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(32'(rd[0]), 32'h0);
      $display("reset test end");
      for (int r = 0; r < 2; r++) begin
         for (int f = 0; f < 8; f++) begin
            role_select_switch <= r[0];
            address_count_switches <= f[2:0];
            repeat (8) @(posedge pclk);
            ext_switch_closed <= 1'b1;
            wait_pow(1'b1);
            role_select_switch <= ~r[0];
            address_count_switches <= ~f[2:0];
            repeat (10) @(posedge pclk);
            chk(32'({cfg.is_host, cfg.standalone, cfg.node_addr}),
               32'({r[0], r == 0 && f == 0, r ? 3'h0 : f[2:0]}));
            if (r == 1 || f == 0) chk(32'(cfg.unit_count), r ? f + 1 : 1);
            chk(32'(can_enable), r);
            chk(32'(rs485_poll_master), r);
            ext_switch_closed <= 1'b0;
            wait_pow(1'b0);
         end
      end
      $display("decode test end");
      role_select_switch <= 1'b1;
      address_count_switches <= 3'h2;
      pack_n <= 4'h3;
      repeat (8) @(posedge pclk);
      reset_button <= 1'b1;
      repeat (6) @(posedge pclk);
      reset_button <= 1'b0;
      wait_pow(1'b1);
      repeat (4 * RS485_BIT_CYC) @(posedge pclk);
      apb(1'b0, REG_TOTAL, 32'h0);
      chk(rd, 32'h303);
      apb(1'b0, REG_COUNT, 32'h0);
      chk(rd, 32'h3);
      $display("gather test end");
      apb(1'b1, REG_CTRL, 32'h2);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h2);
      chk(32'(can_enable), 32'h0);
      chk(32'(rs485_enable), 32'h1);
      reset_button <= 1'b1;
      wait_pow(1'b0);
      reset_button <= 1'b0;
      charger_present <= 1'b1;
      wait_pow(1'b1);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd, 32'h2863);
      $display("power test end");
      close_out();
   end
endmodule
`default_nettype wire
